// *** include/uart_lmc_pkg.sv ***
// Purpose: shared constants and types for the line format / modem control block
// Assumes: 8-bit register port, 3-bit register address
// Notes:   16 ticks of the baud tick make one bit time
package uart_lmc_pkg;

  // register offsets
  localparam logic [2:0] OFS_DATA  = 3'h0;
  localparam logic [2:0] OFS_IRQEN = 3'h1;
  localparam logic [2:0] OFS_LCR   = 3'h3;
  localparam logic [2:0] OFS_MCR   = 3'h4;
  localparam logic [2:0] OFS_LSR   = 3'h5;
  localparam logic [2:0] OFS_MSR   = 3'h6;

  // line_format_control fields
  localparam int LCR_STB   = 2;
  localparam int LCR_PEN   = 3;
  localparam int LCR_EPS   = 4;
  localparam int LCR_STICK = 5;
  localparam int LCR_BRK   = 6;
  localparam int LCR_DIVISOR_ACCESS_SELECT  = 7;

  // handshake_output_control fields
  localparam int MCR_DTR  = 0;
  localparam int MCR_RTS  = 1;
  localparam int MCR_OUTA = 2;
  localparam int MCR_OUTB = 3;
  localparam int MCR_LOOP = 4;
  localparam int MCR_AFE  = 5;

  // reset values
  localparam logic [7:0]  LCR_RST  = 8'h00;
  localparam logic [7:0]  MCR_RST  = 8'h00;
  localparam logic [7:0]  IER_RST  = 8'h00;
  localparam logic [7:0]  IER_MASK = 8'h0F;
  localparam logic [7:0]  MCR_MASK = 8'h3F;
  localparam logic [15:0] DIV_RST  = 16'h0001;

  // timing in baud ticks
  localparam logic [5:0] TICKS_BIT    = 6'h10;
  localparam logic [5:0] TICKS_HALF   = 6'h08;
  localparam logic [5:0] TICKS_STOP15 = 6'h18;
  localparam logic [5:0] TICKS_STOP2  = 6'h20;
  localparam logic [1:0] BRK_HIGH_SAMPLES = 2'h2;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BREAK} rx_state_t;

endpackage

// *** logic/uart_line_modem_control.sv ***
// Purpose: line format, line status and modem control of an async serial element
// Assumes: character mode only (no FIFOs); pins synchronous to clk
// Notes:   divisor latches, holding and buffer registers included so the flags have a cause
`timescale 1ns/1ns
module uart_line_modem_control
  import uart_lmc_pkg::*;
#(
  parameter logic [15:0] DIV_RESET = DIV_RST
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  // serial link
  input  wire logic       serial_rx_pin,
  output logic            serial_tx_pin,
  // modem inputs, active low
  input  wire logic       cts_n,
  input  wire logic       dsr_n,
  input  wire logic       ri_n,
  input  wire logic       dcd_n,
  // modem outputs, active low
  output logic            dtr_n,
  output logic            rts_n,
  output logic            user_output_a_n,
  output logic            user_output_b_n
);

  function automatic logic at(input logic [2:0] a, input logic [2:0] ofs);
    at = (a == ofs);
  endfunction

  // data bits beyond the word length are masked off
  function automatic logic [7:0] len_mask(input logic [1:0] len);
    len_mask = 8'hFF >> (2'h3 - len);
  endfunction

  // parity bit to send or expect for a character
  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] line_format_control);
    logic ones;
    ones = ^(d & len_mask(line_format_control[1:0]));
    if (line_format_control[LCR_STICK]) begin
      par_bit = ~line_format_control[LCR_EPS];
    end else begin
      par_bit = line_format_control[LCR_EPS] ? ones : ~ones;
    end
  endfunction

  logic [7:0]  lcr_ff, mcr_ff, ier_ff, rx_buffer_ff, tx_holding_ff, rdata_ff;
  logic [15:0] div_ff, baud_cnt_ff;
  logic        tick_ff, tx_holding_empty_ff, rx_char_available_ff;
  logic [3:0]  err_ff;
  logic        serial_tx_pin_ff, dtr_n_ff, rts_n_ff, outa_n_ff, outb_n_ff;

  // register decode
  wire divisor_access_select    = lcr_ff[LCR_DIVISOR_ACCESS_SELECT];
  wire loop    = mcr_ff[MCR_LOOP];
  wire wr_low  = wr_stb && at(addr, OFS_DATA);
  wire wr_high = wr_stb && at(addr, OFS_IRQEN);
  wire wr_thr  = wr_low && !divisor_access_select;
  wire wr_dll  = wr_low && divisor_access_select;
  wire wr_dlm  = wr_high && divisor_access_select;
  wire wr_ier  = wr_high && !divisor_access_select;
  wire rd_rbr  = rd_stb && at(addr, OFS_DATA) && !divisor_access_select;
  wire rd_lsr  = rd_stb && at(addr, OFS_LSR);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lcr_ff        <= LCR_RST;
      mcr_ff        <= MCR_RST;
      ier_ff        <= IER_RST;
      div_ff        <= DIV_RESET;
      tx_holding_ff <= 8'h00;
    end else begin
      if (wr_stb && at(addr, OFS_LCR)) lcr_ff <= wdata;
      if (wr_stb && at(addr, OFS_MCR)) mcr_ff <= wdata & MCR_MASK;
      if (wr_ier) ier_ff <= wdata & IER_MASK;
      if (wr_dll) div_ff[7:0] <= wdata;
      if (wr_dlm) div_ff[15:8] <= wdata;
      if (wr_thr) tx_holding_ff <= wdata;
    end
  end

  // baud tick; reloading on a latch write avoids a long first count
  wire [15:0] nxt_div      = wr_dll ? {div_ff[15:8], wdata} :
                             wr_dlm ? {wdata, div_ff[7:0]} : div_ff;
  wire        nxt_tick     = (baud_cnt_ff <= 16'h0001);
  wire [15:0] nxt_baud_cnt = (wr_dll || wr_dlm || nxt_tick) ? nxt_div : baud_cnt_ff - 16'h0001;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_cnt_ff <= DIV_RESET;
      tick_ff     <= 1'b0;
    end else begin
      baud_cnt_ff <= nxt_baud_cnt;
      tick_ff     <= nxt_tick;
    end
  end

  // ---------------- transmitter ----------------
  tx_state_t  tx_st_ff;
  logic [7:0] tx_shifter_ff;
  logic [2:0] tx_bit_ff;
  logic [5:0] tx_cnt_ff;
  logic       tx_par_ff;

  wire [2:0] last_bit   = 3'h4 + {1'b0, lcr_ff[1:0]};
  wire       cts_active = loop ? mcr_ff[MCR_RTS] : !cts_n;
  wire       cts_ok     = !mcr_ff[MCR_AFE] || cts_active;
  wire [5:0] stop_ticks = !lcr_ff[LCR_STB] ? TICKS_BIT :
                          (lcr_ff[1:0] == 2'b00) ? TICKS_STOP15 : TICKS_STOP2;
  wire [5:0] tx_limit   = (tx_st_ff == TX_STOP) ? stop_ticks : TICKS_BIT;
  wire       tx_bit_end = tick_ff && (tx_cnt_ff == tx_limit - 6'h01);
  wire       tx_load    = (tx_st_ff == TX_IDLE) && !tx_holding_empty_ff && cts_ok;
  wire       tx_line    = (tx_st_ff == TX_START) ? 1'b0 :
                          (tx_st_ff == TX_DATA)  ? tx_shifter_ff[0] :
                          (tx_st_ff == TX_PAR)   ? tx_par_ff : 1'b1;
  wire       tx_fully_idle = tx_holding_empty_ff && (tx_st_ff == TX_IDLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_ff      <= TX_IDLE;
      tx_shifter_ff <= 8'h00;
      tx_bit_ff     <= 3'h0;
      tx_cnt_ff     <= 6'h00;
      tx_par_ff     <= 1'b0;
    end else begin
      tx_cnt_ff <= tx_bit_end ? 6'h00 : (tick_ff ? tx_cnt_ff + 6'h01 : tx_cnt_ff);
      case (tx_st_ff)
        TX_IDLE: begin
          tx_cnt_ff <= 6'h00;
          if (tx_load) begin
            tx_shifter_ff <= tx_holding_ff;
            tx_par_ff     <= par_bit(tx_holding_ff, lcr_ff);
            tx_st_ff      <= TX_START;
          end
        end
        TX_START: if (tx_bit_end) begin
          tx_bit_ff <= 3'h0;
          tx_st_ff  <= TX_DATA;
        end
        TX_DATA: if (tx_bit_end) begin
          tx_shifter_ff <= {1'b0, tx_shifter_ff[7:1]};
          tx_bit_ff     <= tx_bit_ff + 3'h1;
          if (tx_bit_ff == last_bit) begin
            tx_st_ff <= lcr_ff[LCR_PEN] ? TX_PAR : TX_STOP;
          end
        end
        TX_PAR:  if (tx_bit_end) tx_st_ff <= TX_STOP;
        TX_STOP: if (tx_bit_end) tx_st_ff <= TX_IDLE;
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // a write in the cycle of a move wins: the holding register is full again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_holding_empty_ff <= 1'b1;
    end else if (wr_thr) begin
      tx_holding_empty_ff <= 1'b0;
    end else if (tx_load) begin
      tx_holding_empty_ff <= 1'b1;
    end
  end

  // ---------------- receiver ----------------
  rx_state_t  rx_st_ff;
  logic [7:0] rx_shift_ff;
  logic [2:0] rx_bit_ff;
  logic [5:0] rx_cnt_ff;
  logic [1:0] rx_high_ff;
  logic       rx_zero_ff, rx_perr_ff;

  wire       rx_in     = loop ? tx_line : serial_rx_pin;
  wire [5:0] rx_limit  = (rx_st_ff == RX_START) ? TICKS_HALF : TICKS_BIT;
  wire       rx_sample = tick_ff && (rx_cnt_ff == rx_limit - 6'h01);
  wire       rx_load   = (rx_st_ff == RX_STOP) && rx_sample;
  wire       rx_brk    = rx_load && !rx_in && rx_zero_ff;
  wire       rx_fe     = rx_load && !rx_in && !rx_zero_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_ff    <= RX_IDLE;
      rx_shift_ff <= 8'h00;
      rx_bit_ff   <= 3'h0;
      rx_cnt_ff   <= 6'h00;
      rx_high_ff  <= 2'h0;
      rx_zero_ff  <= 1'b0;
      rx_perr_ff  <= 1'b0;
    end else begin
      rx_cnt_ff <= rx_sample ? 6'h00 : (tick_ff ? rx_cnt_ff + 6'h01 : rx_cnt_ff);
      case (rx_st_ff)
        RX_IDLE: begin
          rx_cnt_ff <= 6'h00;
          if (!rx_in) rx_st_ff <= RX_START;
        end
        RX_START: if (rx_sample) begin
          rx_st_ff    <= rx_in ? RX_IDLE : RX_DATA;
          rx_bit_ff   <= 3'h0;
          rx_shift_ff <= 8'h00;
          rx_zero_ff  <= 1'b1;
          rx_perr_ff  <= 1'b0;
        end
        RX_DATA: if (rx_sample) begin
          rx_shift_ff[rx_bit_ff] <= rx_in;
          rx_zero_ff <= rx_zero_ff && !rx_in;
          rx_bit_ff  <= rx_bit_ff + 3'h1;
          if (rx_bit_ff == last_bit) begin
            rx_st_ff <= lcr_ff[LCR_PEN] ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: if (rx_sample) begin
          rx_perr_ff <= (rx_in != par_bit(rx_shift_ff, lcr_ff));
          rx_zero_ff <= rx_zero_ff && !rx_in;
          rx_st_ff   <= RX_STOP;
        end
        RX_STOP: if (rx_sample) begin
          rx_high_ff <= 2'h0;
          // low stop bit is the next start: recheck on the next tick, keep its mid-bit phase
          rx_cnt_ff  <= rx_fe ? TICKS_HALF - 6'h01 : 6'h00;
          rx_st_ff <= rx_brk ? RX_BREAK : (rx_fe ? RX_START : RX_IDLE);
        end
        RX_BREAK: if (tick_ff) begin
          rx_high_ff <= rx_in ? rx_high_ff + 2'h1 : 2'h0;
          if (rx_in && rx_high_ff == BRK_HIGH_SAMPLES - 2'h1) rx_st_ff <= RX_IDLE;
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // line status flags; a set in the cycle of a clear wins
  wire [3:0] err_set = {rx_brk,
                        rx_fe,
                        rx_load && lcr_ff[LCR_PEN] && rx_perr_ff && !rx_brk,
                        rx_load && rx_char_available_ff && !rd_rbr};

  generate
    for (genvar i = 0; i < 4; i++) begin : g_err
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          err_ff[i] <= 1'b0;
        end else if (err_set[i]) begin
          err_ff[i] <= 1'b1;
        end else if (rd_lsr) begin
          err_ff[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_char_available_ff <= 1'b0;
      rx_buffer_ff         <= 8'h00;
    end else if (rx_load) begin
      rx_char_available_ff <= 1'b1;
      rx_buffer_ff         <= rx_brk ? 8'h00 : rx_shift_ff;
    end else if (rd_rbr) begin
      rx_char_available_ff <= 1'b0;
    end
  end

  // ---------------- read side ----------------
  wire       rx_fifo_error_summary = 1'b0;
  wire [7:0] line_condition_flags = {rx_fifo_error_summary, tx_fully_idle, tx_holding_empty_ff,
                    err_ff, rx_char_available_ff};
  wire [3:0] modem_in = loop ? {mcr_ff[MCR_OUTB], mcr_ff[MCR_OUTA],
                                mcr_ff[MCR_DTR], mcr_ff[MCR_RTS]} :
                               {!dcd_n, !ri_n, !dsr_n, !cts_n};
  wire [7:0] rd_mux = at(addr, OFS_DATA)  ? (divisor_access_select ? div_ff[7:0] : rx_buffer_ff) :
                      at(addr, OFS_IRQEN) ? (divisor_access_select ? div_ff[15:8] : ier_ff) :
                      at(addr, OFS_LCR)   ? lcr_ff :
                      at(addr, OFS_MCR)   ? mcr_ff :
                      at(addr, OFS_LSR)   ? line_condition_flags :
                      at(addr, OFS_MSR)   ? {modem_in, 4'h0} : 8'h00;

  // auto RTS drops request while an unread character waits
  wire auto_rts = mcr_ff[MCR_AFE] && mcr_ff[MCR_RTS];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff         <= 8'h00;
      serial_tx_pin_ff <= 1'b1;
      dtr_n_ff         <= 1'b1;
      rts_n_ff         <= 1'b1;
      outa_n_ff        <= 1'b1;
      outb_n_ff        <= 1'b1;
    end else begin
      rdata_ff         <= rd_stb ? rd_mux : 8'h00;
      serial_tx_pin_ff <= loop ? 1'b1 : (lcr_ff[LCR_BRK] ? 1'b0 : tx_line);
      dtr_n_ff         <= loop || !mcr_ff[MCR_DTR];
      rts_n_ff         <= loop || (auto_rts ? rx_char_available_ff : !mcr_ff[MCR_RTS]);
      outa_n_ff        <= loop || !mcr_ff[MCR_OUTA];
      outb_n_ff        <= loop || !mcr_ff[MCR_OUTB];
    end
  end

  assign rdata           = rdata_ff;
  assign serial_tx_pin   = serial_tx_pin_ff;
  assign dtr_n           = dtr_n_ff;
  assign rts_n           = rts_n_ff;
  assign user_output_a_n = outa_n_ff;
  assign user_output_b_n = outb_n_ff;

  // ---------------- checks ----------------
  a_break_forces_low: assert property (@(posedge clk) disable iff (!rst_n)
    lcr_ff[LCR_BRK] && !loop |=> !serial_tx_pin)
    else $error("break set but serial output not low");

  a_loop_tx_high: assert property (@(posedge clk) disable iff (!rst_n)
    loop |=> serial_tx_pin && dtr_n && rts_n && user_output_a_n && user_output_b_n)
    else $error("loopback did not hold outputs high");

  a_modem_invert: assert property (@(posedge clk) disable iff (!rst_n)
    !loop |=> dtr_n == !$past(mcr_ff[MCR_DTR]) && user_output_b_n == !$past(mcr_ff[MCR_OUTB]))
    else $error("modem output polarity wrong");

  a_idle_both_empty: assert property (@(posedge clk) disable iff (!rst_n)
    line_condition_flags[6] |-> tx_holding_empty_ff && tx_st_ff == TX_IDLE)
    else $error("transmitter idle flag with data present");

  a_idle_line_high: assert property (@(posedge clk) disable iff (!rst_n)
    line_condition_flags[6] && !lcr_ff[LCR_BRK] |=> serial_tx_pin)
    else $error("transmitter idle but serial output not at mark");

  a_tx_holding_empty_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_thr |=> !line_condition_flags[5] ##1 1'b1)
    else $error("holding empty not cleared by write");

  a_divisor_access_select_blocks_thr: assert property (@(posedge clk) disable iff (!rst_n)
    wr_low && divisor_access_select |=> $stable(tx_holding_ff) && div_ff[7:0] == $past(wdata))
    else $error("data offset write missed the divisor latch");

  a_dr_on_load: assert property (@(posedge clk) disable iff (!rst_n)
    rx_load |=> rx_char_available_ff && line_condition_flags[0])
    else $error("data ready not set after a character");

  a_lsr_clear: assert property (@(posedge clk) disable iff (!rst_n)
    rd_lsr && !rx_load |=> err_ff == 4'h0)
    else $error("error flags survived a status read");

  a_overrun: assert property (@(posedge clk) disable iff (!rst_n)
    rx_load && rx_char_available_ff && !rd_rbr |=> err_ff[0])
    else $error("overwrite of unread character not flagged");

  a_break_zero: assert property (@(posedge clk) disable iff (!rst_n)
    rx_brk |=> rx_buffer_ff == 8'h00 && err_ff[3] && rx_st_ff == RX_BREAK)
    else $error("break did not load a zero character");

  a_stop_length: assert property (@(posedge clk) disable iff (!rst_n)
    tx_st_ff == TX_STOP && tick_ff && tx_cnt_ff == 6'h0F && lcr_ff[LCR_STB] |=> tx_st_ff == TX_STOP)
    else $error("second stop bit was cut short");

endmodule

// *** dv/uart_lmc_peer.sv ***
// Purpose: modem or serial peripheral at the far end of the link
// Assumes: divisor 1, so one bit is 16 clocks
// Notes:   link idles at mark (high); modem lines idle inactive high
`timescale 1ns/1ns
module uart_lmc_peer (
  // clock
  input  wire logic clk,
  // serial link
  input  wire logic serial_tx_pin,
  output logic      serial_rx_pin,
  // modem lines, active low
  output logic      cts_n,
  output logic      dsr_n,
  output logic      ri_n,
  output logic      dcd_n
);
  int   gap_ff;
  int   run_ff;
  logic last_ff;

  initial begin
    serial_rx_pin = 1'b1;
    {dcd_n, ri_n, dsr_n, cts_n} = 4'hF;
    gap_ff = 0;
    run_ff = 0;
    last_ff = 1'b1;
  end

  // clocks between start edges, to measure frame length
  always @(posedge clk) begin
    last_ff <= serial_tx_pin;
    run_ff  <= run_ff + 1;
    if (last_ff && !serial_tx_pin) begin
      gap_ff <= run_ff;
      run_ff <= 1;
    end
  end

  task automatic set_modem(input logic [3:0] m);
    {dcd_n, ri_n, dsr_n, cts_n} <= m;
  endtask

  task automatic bit_out(input logic b);
    @(posedge clk);
    serial_rx_pin <= b;
    repeat (15) @(posedge clk);
  endtask

  // st low skips the start bit, to follow a low stop bit seamlessly;
  // a low stop bit is left standing so the next frame follows with no mark glitch
  task automatic send(input logic [7:0] d, input int nb, input logic pe, input logic pv,
                      input logic sb, input logic st);
    if (st) bit_out(1'b0);
    for (int i = 0; i < nb; i++) bit_out(d[i]);
    if (pe) bit_out(pv);
    bit_out(sb);
    if (sb) begin
      @(posedge clk);
      serial_rx_pin <= 1'b1;
    end
  endtask

  task automatic line_low(input int n);
    @(posedge clk);
    serial_rx_pin <= 1'b0;
    repeat (n * 16) @(posedge clk);
    serial_rx_pin <= 1'b1;
  endtask

  // samples each bit in its middle, lsb first
  task automatic grab(input int nb, input logic pe, output logic [8:0] v);
    v = 9'h000;
    // a low last bit of the previous frame must not pass for a start bit
    while (serial_tx_pin !== 1'b1) @(posedge clk);
    while (serial_tx_pin !== 1'b0) @(posedge clk);
    repeat (8) @(posedge clk);
    for (int i = 0; i < nb + int'(pe); i++) begin
      repeat (16) @(posedge clk);
      v[i] = serial_tx_pin;
    end
  endtask
endmodule

// *** dv/uart_line_modem_control_tb.sv ***
// Purpose: self-checking bench for the line format and modem control block
// Assumes: divisor left at 1, so a bit is 16 clocks
// Notes:   the bench is the host; uart_lmc_peer is the far end
`timescale 1ns/1ns
module uart_line_modem_control_tb
  import uart_lmc_pkg::*;
;
  logic       clk;
  logic       rst_n;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] rdata;
  logic       rx_line;
  logic       tx_line;
  logic [3:0] mdm_in;
  logic [3:0] mdm_out;
  int         errors;
  int         check_count;
  int         cyc;
  logic [7:0] v;
  logic [8:0] got;
  logic [7:0] dm;
  logic       pe;
  logic       par;
  logic       lo;
  int         nb;
  logic [7:0] pm [5];
  logic [7:0] msr_exp [4];
  logic [7:0] gap_lcr [3];
  int         gap_exp [3];

  uart_line_modem_control uut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .serial_rx_pin(rx_line), .serial_tx_pin(tx_line),
    .cts_n(mdm_in[0]), .dsr_n(mdm_in[1]), .ri_n(mdm_in[2]), .dcd_n(mdm_in[3]),
    .dtr_n(mdm_out[0]), .rts_n(mdm_out[1]), .user_output_a_n(mdm_out[2]),
    .user_output_b_n(mdm_out[3]));

  uart_lmc_peer peer (
    .clk(clk), .serial_tx_pin(tx_line), .serial_rx_pin(rx_line), .cts_n(mdm_in[0]),
    .dsr_n(mdm_in[1]), .ri_n(mdm_in[2]), .dcd_n(mdm_in[3]));

  task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rdc(input string name, input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    v = rdata;
    chk(name, {1'b0, v}, {1'b0, e});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic stop_test();
    if (errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // the whole run needs about 9000 clocks
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    errors = 0;
    check_count = 0;
    cyc = 0;
    pm = '{8'h00, 8'h08, 8'h18, 8'h28, 8'h38};
    msr_exp = '{8'h20, 8'h10, 8'h40, 8'h80};
    gap_lcr = '{8'h04, 8'h07, 8'h03};
    gap_exp = '{120, 176, 160};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("pins", {4'h0, mdm_out, tx_line}, 9'h01F);
    rdc("lcr", OFS_LCR, 8'h00);
    rdc("mcr", OFS_MCR, 8'h00);
    rdc("lsr", OFS_LSR, 8'h60);
    rdc("ier", OFS_IRQEN, 8'h00);
    // a write to the unmapped offset 7 is dropped; it reads back as zero
    wr(3'h7, 8'hFF);
    rdc("unmapped", 3'h7, 8'h00);
    wr(OFS_LCR, 8'h80);
    wr(OFS_DATA, 8'h01);
    wr(OFS_IRQEN, 8'h00);
    rdc("div_lo", OFS_DATA, 8'h01);
    rdc("lsr_divisor_access_select", OFS_LSR, 8'h60);
    wr(OFS_LCR, 8'h03);
    wr(OFS_IRQEN, 8'hFF);
    rdc("ier", OFS_IRQEN, 8'h0F);
    wr(OFS_LCR, 8'h83);
    rdc("div_hi", OFS_IRQEN, 8'h00);
    wr(OFS_LCR, 8'h03);
    peer.set_modem(4'hE);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_MCR, 8'h01 << i);
      idle(2);
      chk("mdm_out", {5'h00, mdm_out}, {5'h00, ~(4'h1 << i)});
      wr(OFS_MCR, 8'h10 | (8'h01 << i));
      idle(2);
      chk("mdm_loop", {5'h00, mdm_out}, 9'h00F);
      rdc("msr_loop", OFS_MSR, msr_exp[i]);
    end
    wr(OFS_MCR, 8'h00);
    idle(4);
    rdc("msr", OFS_MSR, 8'h10);
    peer.set_modem(4'h5);
    rdc("msr_pins", OFS_MSR, 8'hA0);
    peer.set_modem(4'hA);
    rdc("msr_pins2", OFS_MSR, 8'h50);
    peer.set_modem(4'hF);
    wr(OFS_MCR, 8'h22);
    wr(OFS_DATA, 8'h55);
    idle(48);
    rdc("lsr_cts", OFS_LSR, 8'h00);
    chk("rts_auto", {8'h00, mdm_out[1]}, 9'h000);
    peer.set_modem(4'hE);
    peer.grab(8, 1'b0, got);
    chk("tx_cts", got, 9'h055);
    wr(OFS_MCR, 8'h02);
    peer.set_modem(4'hF);
    wr(OFS_DATA, 8'h3C);
    peer.grab(8, 1'b0, got);
    chk("tx_noflow", got, 9'h03C);
    wr(OFS_MCR, 8'h00);
    wr(OFS_LCR, 8'h43);
    idle(2);
    chk("brk_on", {8'h00, tx_line}, 9'h000);
    wr(OFS_LCR, 8'h03);
    idle(2);
    chk("brk_off", {8'h00, tx_line}, 9'h001);
    for (int w = 0; w < 4; w++) begin
      for (int p = 0; p < 5; p++) begin
        nb = 5 + w;
        pe = pm[p][3];
        dm = (8'hA6 + 8'(w * 3 + p)) & (8'hFF >> (3 - w));
        par = pm[p][5] ? ~pm[p][4] : (pm[p][4] ? ^dm : ~^dm);
        wr(OFS_LCR, pm[p] | 8'(w));
        peer.send(dm, nb, pe, par, 1'b1, 1'b1);
        idle(4);
        rdc("lsr_rx", OFS_LSR, 8'h61);
        rdc("rx_data", OFS_DATA, dm);
        wr(OFS_DATA, dm);
        peer.grab(nb, pe, got);
        chk("tx_frame", got, {1'b0, dm} | ({8'h00, par & pe} << nb));
      end
    end
    wr(OFS_LCR, 8'h1B);
    peer.send(8'h01, 8, 1'b1, 1'b0, 1'b1, 1'b1);
    idle(4);
    rdc("lsr_par", OFS_LSR, 8'h65);
    rdc("rx_data", OFS_DATA, 8'h01);
    rdc("lsr_clr", OFS_LSR, 8'h60);
    wr(OFS_LCR, 8'h1F);
    peer.send(8'h24, 8, 1'b1, 1'b0, 1'b1, 1'b1);
    peer.send(8'h42, 8, 1'b1, 1'b0, 1'b1, 1'b1);
    idle(4);
    rdc("lsr_ovr", OFS_LSR, 8'h63);
    rdc("lsr_ovr2", OFS_LSR, 8'h61);
    rdc("rx_data", OFS_DATA, 8'h42);
    peer.send(8'h81, 8, 1'b1, 1'b0, 1'b0, 1'b1);
    peer.send(8'h18, 8, 1'b1, 1'b0, 1'b1, 1'b0);
    idle(4);
    rdc("lsr_frm", OFS_LSR, 8'h6B);
    rdc("rx_resync", OFS_DATA, 8'h18);
    peer.line_low(12);
    idle(40);
    rdc("lsr_brk", OFS_LSR, 8'h71);
    rdc("rx_brk", OFS_DATA, 8'h00);
    rdc("lsr_clr", OFS_LSR, 8'h60);
    for (int j = 0; j < 3; j++) begin
      wr(OFS_LCR, gap_lcr[j]);
      wr(OFS_DATA, 8'hFF);
      wr(OFS_DATA, 8'hFF);
      rdc("lsr_full", OFS_LSR, 8'h00);
      idle(gap_exp[j] + 8);
      rdc("lsr_tx_holding_empty", OFS_LSR, 8'h20);
      idle(gap_exp[j]);
      rdc("lsr_idle", OFS_LSR, 8'h60);
      chk("gap", {8'h00, peer.gap_ff >= gap_exp[j] && peer.gap_ff <= gap_exp[j] + 3}, 9'h001);
    end
    wr(OFS_LCR, 8'h03);
    wr(OFS_MCR, 8'h10);
    wr(OFS_DATA, 8'h5A);
    lo = 1'b0;
    fork
      peer.line_low(4);
      for (int k = 0; k < 200; k++) begin
        @(posedge clk);
        lo = lo | ~tx_line;
      end
    join
    chk("tx_loop", {8'h00, lo}, 9'h000);
    rdc("lsr_loop", OFS_LSR, 8'h61);
    rdc("rx_loop", OFS_DATA, 8'h5A);
    stop_test();
  end
endmodule
